//--- design/frd_defs.vh
`ifndef FRD_DEFS_VH
`define FRD_DEFS_VH

// opcodes of the register, protection and reset groups and the octal array reads
`define FRD_OP_STATUS_RD   8'h05
`define FRD_OP_CONFIG_RD   8'h15
`define FRD_OP_SC_WR       8'h01
`define FRD_OP_CR2_RD      8'h71
`define FRD_OP_CR2_WR      8'h72
`define FRD_OP_SEC_RD      8'h2b
`define FRD_OP_SEC_WR      8'h2f
`define FRD_OP_FB_RD       8'h16
`define FRD_OP_FB_WR       8'h17
`define FRD_OP_FB_ER       8'h18
`define FRD_OP_OTP_EN      8'hb1
`define FRD_OP_OTP_EX      8'hc1
`define FRD_OP_SPB_PG      8'he3
`define FRD_OP_SPB_ER      8'he4
`define FRD_OP_PASS_RD     8'h27
`define FRD_OP_PASS_WR     8'h28
`define FRD_OP_RST_ARM     8'h66
`define FRD_OP_RST         8'h99
`define FRD_OP_OCT_SDR_RD  8'hec
`define FRD_OP_OCT_DDR_RD  8'hee

// dummy cycles per interface
`define FRD_PASS_DUMMY_SPI 5'h08
`define FRD_REG_DUMMY_OCT  5'h04
`define FRD_PASS_DUMMY_OCT 5'h14
`define FRD_ARR_DUMMY_OCT  5'h14

// data byte counts and last address byte index
`define FRD_FB_BYTES       4'h4
`define FRD_PASS_BYTES     4'h8
`define FRD_ADDR_LAST      3'h3

// reset values
`define FRD_STATUS_RST     8'h00
`define FRD_CONFIG_RST     8'h00
`define FRD_CR2_RST        8'h00
`define FRD_SEC_RST        8'h00
`define FRD_FB_RST         32'hffffffff
`define FRD_PASS_RST       64'hffffffffffffffff
`define FRD_SPB_RST        8'h00

// field positions
`define FRD_SEC_LOCK_BIT   1
`define FRD_CR2_OCT_BIT    0
`define FRD_CR2_DDR_BIT    1
`define FRD_SPB_SEL_HI     18
`define FRD_SPB_SEL_LO     16

`endif

//--- design/frd_sync.v
`timescale 1ns/1ps
`default_nettype none

module frd_sync (
   // clock and reset
   input  wire        clk,
   input  wire        resetn,
   // raw pins: cs_n, sclk, si, dq[7:0]
   input  wire [10:0] async_in,
   // synchronised copies
   output wire [10:0] sync_out
);

   reg [10:0] meta_reg;
   reg [10:0] sync_reg;

   // two flops per bit; the first is read only by the second
   genvar gi;
   generate
      for (gi = 0; gi < 11; gi = gi + 1) begin : g_bit
         always @(posedge clk) begin
            if (!resetn) begin
               meta_reg[gi] <= (gi == 10) ? 1'b1 : 1'b0;
               sync_reg[gi] <= (gi == 10) ? 1'b1 : 1'b0;
            end else begin
               meta_reg[gi] <= async_in[gi];
               sync_reg[gi] <= meta_reg[gi];
            end
         end
      end
   endgenerate

   assign sync_out = sync_reg;

endmodule

`default_nettype wire

//--- design/frd_decoder.v
`include "frd_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module frd_decoder (
   // clock and reset
   input  wire       clk,
   input  wire       resetn,
   // serial pins
   input  wire       cs_n,
   input  wire       sclk,
   input  wire       si,
   output reg        so,
   output reg        so_oe_n,
   // octal data pins
   input  wire [7:0] dq_in,
   output reg  [7:0] dq_out,
   output reg        dq_oe_n,
   // device state
   output reg        otp_active,
   output reg  [7:0] spb_bits,
   output reg        mem_reset
);

   localparam ST_IDLE  = 3'h0;
   localparam ST_CMD   = 3'h1;
   localparam ST_CMD2  = 3'h2;
   localparam ST_ADDR  = 3'h3;
   localparam ST_DUMMY = 3'h4;
   localparam ST_DIN   = 3'h5;
   localparam ST_DOUT  = 3'h6;
   localparam ST_DONE  = 3'h7;

   localparam K_NONE = 2'h0;
   localparam K_RD   = 2'h1;
   localparam K_WR   = 2'h2;

   wire [10:0] sync_w;
   wire        cs_s;
   wire        sclk_s;
   wire        si_s;
   wire [7:0]  dq_s;

   reg         sclk_q;
   reg         cs_q;
   reg  [2:0]  state_reg;
   reg         ign_reg;
   reg         oct_reg;
   reg         ddr_reg;
   reg  [2:0]  bitcnt_reg;
   reg  [7:0]  shreg_reg;
   reg  [7:0]  op_reg;
   reg  [4:0]  cnt_reg;
   reg  [31:0] addr_reg;
   reg  [63:0] stage_reg;
   reg  [2:0]  idx_reg;
   reg  [2:0]  obit_reg;
   reg  [7:0]  tx_reg;
   reg         armed_reg;
   reg  [7:0]  status_reg;
   reg  [7:0]  config_reg;
   reg  [7:0]  cr2_reg;
   reg  [7:0]  sec_reg;
   reg  [31:0] fb_reg;
   reg  [63:0] pass_reg;

   frd_sync u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({cs_n, sclk, si, dq_in}),
      .sync_out (sync_w)
   );

   assign cs_s   = sync_w[10];
   assign sclk_s = sync_w[9];
   assign si_s   = sync_w[8];
   assign dq_s   = sync_w[7:0];

   // edges of the sampled serial clock and chip select
   wire rise    = sclk_s & ~sclk_q;
   wire fall    = ~sclk_s & sclk_q;
   wire cs_fall = ~cs_s & cs_q;
   wire cs_rise = cs_s & ~cs_q;
   wire cap     = rise | (oct_reg & ddr_reg & fall);
   wire launch  = fall | (oct_reg & ddr_reg & rise);

   wire [7:0] byte_in   = oct_reg ? dq_s : {shreg_reg[6:0], si_s};
   wire       byte_done = cap & (oct_reg | (bitcnt_reg == 3'h7));
   wire [7:0] dec_op    = (state_reg == ST_CMD) ? byte_in : op_reg;
   wire [2:0] idx_inc   = idx_reg + 3'h1;

   // command table: validity, address, dummy cycles, kind of data phase
   reg       dec_valid;
   reg       dec_addr;
   reg [4:0] dec_dummy;
   reg [1:0] dec_kind;
   always @* begin
      dec_valid = 1'b1;
      dec_addr  = 1'b0;
      dec_dummy = 5'h00;
      dec_kind  = K_NONE;
      case (dec_op)
         `FRD_OP_STATUS_RD: dec_kind = K_RD;
         `FRD_OP_CONFIG_RD: dec_kind = K_RD;
         `FRD_OP_SC_WR:     dec_kind = K_WR;
         `FRD_OP_CR2_RD: begin
            dec_kind = K_RD;
            dec_addr = 1'b1;
         end
         `FRD_OP_CR2_WR: begin
            dec_kind = K_WR;
            dec_addr = 1'b1;
         end
         `FRD_OP_SEC_RD:    dec_kind = K_RD;
         `FRD_OP_SEC_WR:    dec_kind = K_NONE;
         `FRD_OP_FB_RD:     dec_kind = K_RD;
         `FRD_OP_FB_WR:     dec_kind = K_WR;
         `FRD_OP_FB_ER:     dec_kind = K_NONE;
         `FRD_OP_OTP_EN:    dec_kind = K_NONE;
         `FRD_OP_OTP_EX:    dec_kind = K_NONE;
         `FRD_OP_SPB_PG:    dec_addr = 1'b1;
         `FRD_OP_SPB_ER:    dec_kind = K_NONE;
         `FRD_OP_PASS_RD: begin
            dec_kind  = K_RD;
            dec_addr  = 1'b1;
            dec_dummy = `FRD_PASS_DUMMY_SPI;
         end
         `FRD_OP_PASS_WR: begin
            dec_kind = K_WR;
            dec_addr = 1'b1;
         end
         `FRD_OP_RST_ARM:   dec_kind = K_NONE;
         `FRD_OP_RST:       dec_kind = K_NONE;
         `FRD_OP_OCT_SDR_RD: begin
            dec_valid = oct_reg & ~ddr_reg;
            dec_kind  = K_RD;
         end
         `FRD_OP_OCT_DDR_RD: begin
            dec_valid = oct_reg & ddr_reg;
            dec_kind  = K_RD;
         end
         default:           dec_valid = 1'b0;
      endcase
      // octal frames carry four address bytes unless instruction only
      if (oct_reg && (dec_kind != K_NONE || dec_op == `FRD_OP_SPB_PG)) begin
         dec_addr = 1'b1;
         if (dec_kind == K_RD) begin
            if (dec_op == `FRD_OP_PASS_RD) begin
               dec_dummy = `FRD_PASS_DUMMY_OCT;
            end else if (dec_op == `FRD_OP_OCT_SDR_RD || dec_op == `FRD_OP_OCT_DDR_RD) begin
               dec_dummy = `FRD_ARR_DUMMY_OCT;
            end else begin
               dec_dummy = `FRD_REG_DUMMY_OCT;
            end
         end
      end
   end

   // phase after the address and after the opcode
   reg [2:0] post_addr_st;
   reg [2:0] post_op_st;
   always @* begin
      if (dec_dummy != 5'h00) begin
         post_addr_st = ST_DUMMY;
      end else if (dec_kind == K_RD) begin
         post_addr_st = ST_DOUT;
      end else if (dec_kind == K_WR) begin
         post_addr_st = ST_DIN;
      end else begin
         post_addr_st = ST_DONE;
      end
      post_op_st = dec_addr ? ST_ADDR : post_addr_st;
   end

   // byte to be shifted out; array data is not modelled and reads zero
   function [7:0] out_byte;
      input [7:0] o;
      input [2:0] i;
      begin
         case (o)
            `FRD_OP_STATUS_RD: out_byte = status_reg;
            `FRD_OP_CONFIG_RD: out_byte = config_reg;
            `FRD_OP_CR2_RD:    out_byte = cr2_reg;
            `FRD_OP_SEC_RD:    out_byte = sec_reg;
            `FRD_OP_FB_RD:     out_byte = fb_reg[{i[1:0], 3'h0} +: 8];
            `FRD_OP_PASS_RD:   out_byte = pass_reg[{i, 3'h0} +: 8];
            default:           out_byte = 8'h00;
         endcase
      end
   endfunction

   // frame engine and register state
   always @(posedge clk) begin
      if (!resetn) begin
         sclk_q     <= 1'b0;
         cs_q       <= 1'b1;
         state_reg  <= ST_IDLE;
         ign_reg    <= 1'b0;
         oct_reg    <= 1'b0;
         ddr_reg    <= 1'b0;
         bitcnt_reg <= 3'h0;
         shreg_reg  <= 8'h00;
         op_reg     <= 8'h00;
         cnt_reg    <= 5'h00;
         addr_reg   <= 32'h00000000;
         stage_reg  <= 64'h0000000000000000;
         idx_reg    <= 3'h0;
         obit_reg   <= 3'h0;
         tx_reg     <= 8'h00;
         armed_reg  <= 1'b0;
         status_reg <= `FRD_STATUS_RST;
         config_reg <= `FRD_CONFIG_RST;
         cr2_reg    <= `FRD_CR2_RST;
         sec_reg    <= `FRD_SEC_RST;
         fb_reg     <= `FRD_FB_RST;
         pass_reg   <= `FRD_PASS_RST;
         otp_active <= 1'b0;
         spb_bits   <= `FRD_SPB_RST;
         mem_reset  <= 1'b0;
         so         <= 1'b0;
         so_oe_n    <= 1'b1;
         dq_out     <= 8'h00;
         dq_oe_n    <= 1'b1;
      end else begin
         sclk_q    <= sclk_s;
         cs_q      <= cs_s;
         mem_reset <= 1'b0;
         if (cs_fall) begin
            // mode is fixed for the whole frame
            state_reg  <= ST_CMD;
            ign_reg    <= 1'b0;
            oct_reg    <= cr2_reg[`FRD_CR2_OCT_BIT];
            ddr_reg    <= cr2_reg[`FRD_CR2_DDR_BIT];
            bitcnt_reg <= 3'h0;
            cnt_reg    <= 5'h00;
         end else if (cs_rise) begin
            so_oe_n   <= 1'b1;
            dq_oe_n   <= 1'b1;
            state_reg <= ST_IDLE;
            // a frame that never finished its opcode is no command at all
            if (ign_reg || state_reg > ST_CMD2) begin
               armed_reg <= ~ign_reg && state_reg == ST_DONE &&
                            op_reg == `FRD_OP_RST_ARM;
            end
            if (!ign_reg && state_reg == ST_DONE) begin
               case (op_reg)
                  `FRD_OP_SEC_WR: sec_reg[`FRD_SEC_LOCK_BIT] <= 1'b1;
                  `FRD_OP_FB_ER:  fb_reg <= `FRD_FB_RST;
                  `FRD_OP_OTP_EN: otp_active <= 1'b1;
                  `FRD_OP_OTP_EX: otp_active <= 1'b0;
                  `FRD_OP_SPB_PG:
                     spb_bits[addr_reg[`FRD_SPB_SEL_HI:`FRD_SPB_SEL_LO]] <= 1'b1;
                  `FRD_OP_SPB_ER: spb_bits <= `FRD_SPB_RST;
                  `FRD_OP_RST: begin
                     if (armed_reg) begin
                        mem_reset  <= 1'b1;
                        status_reg <= `FRD_STATUS_RST;
                        config_reg <= `FRD_CONFIG_RST;
                        cr2_reg    <= `FRD_CR2_RST;
                        otp_active <= 1'b0;
                     end
                  end
                  default: ;
               endcase
            end
            // fastboot and password writes commit only when the low four bits of the byte count equal the full count
            if (!ign_reg && state_reg == ST_DIN) begin
               if (op_reg == `FRD_OP_FB_WR && cnt_reg[3:0] == `FRD_FB_BYTES) begin
                  fb_reg <= stage_reg[63:32];  // bytes enter at the top
               end
               if (op_reg == `FRD_OP_PASS_WR && cnt_reg[3:0] == `FRD_PASS_BYTES) begin
                  pass_reg <= stage_reg;
               end
            end
         end else if (!cs_s && !ign_reg && state_reg != ST_IDLE) begin
            if (cap && !oct_reg) begin
               shreg_reg  <= byte_in;
               bitcnt_reg <= bitcnt_reg + 3'h1;
            end
            // dummy cycles count rising edges in either rate
            if (rise && state_reg == ST_DUMMY) begin
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == dec_dummy - 5'h01) begin
                  state_reg <= post_addr_st == ST_DUMMY ? ST_DOUT : post_addr_st;
                  cnt_reg   <= 5'h00;
                  idx_reg   <= 3'h0;
                  obit_reg  <= 3'h0;
                  tx_reg    <= out_byte(op_reg, 3'h0);
               end
            end
            if (byte_done) begin
               case (state_reg)
                  ST_CMD: begin
                     op_reg <= byte_in;
                     if (oct_reg) begin
                        state_reg <= ST_CMD2;
                     end else if (!dec_valid) begin
                        ign_reg <= 1'b1;
                     end else begin
                        state_reg <= post_op_st;
                        idx_reg   <= 3'h0;
                        obit_reg  <= 3'h0;
                        tx_reg    <= out_byte(byte_in, 3'h0);
                     end
                  end
                  ST_CMD2: begin
                     if (byte_in != ~op_reg || !dec_valid) begin
                        ign_reg <= 1'b1;
                     end else begin
                        state_reg <= post_op_st;
                     end
                  end
                  ST_ADDR: begin
                     addr_reg <= {addr_reg[23:0], byte_in};
                     cnt_reg  <= cnt_reg + 5'h01;
                     if (cnt_reg[2:0] == `FRD_ADDR_LAST) begin
                        state_reg <= post_addr_st;
                        cnt_reg   <= 5'h00;
                        idx_reg   <= 3'h0;
                        obit_reg  <= 3'h0;
                        tx_reg    <= out_byte(op_reg, 3'h0);
                     end
                  end
                  ST_DIN: begin
                     if (cnt_reg != 5'h1f) begin
                        cnt_reg <= cnt_reg + 5'h01;
                     end
                     stage_reg <= {byte_in, stage_reg[63:8]};
                     if (op_reg == `FRD_OP_SC_WR) begin
                        if (cnt_reg == 5'h00 && !(oct_reg && addr_reg[0])) begin
                           status_reg <= byte_in;
                        end else if (cnt_reg == 5'h01 || (cnt_reg == 5'h00 && oct_reg)) begin
                           config_reg <= byte_in;
                        end
                     end
                     if (op_reg == `FRD_OP_CR2_WR && cnt_reg == 5'h00) begin
                        cr2_reg <= byte_in;
                     end
                  end
                  default: ;
               endcase
            end
            // output phase runs until chip select rises
            if (launch && state_reg == ST_DOUT) begin
               if (oct_reg) begin
                  dq_oe_n <= 1'b0;
                  dq_out  <= tx_reg;
                  tx_reg  <= out_byte(op_reg, idx_inc);
                  idx_reg <= idx_inc;
               end else begin
                  so_oe_n  <= 1'b0;
                  so       <= tx_reg[7];
                  obit_reg <= obit_reg + 3'h1;
                  if (obit_reg == 3'h7) begin
                     tx_reg  <= out_byte(op_reg, idx_inc);
                     idx_reg <= idx_inc;
                  end else begin
                     tx_reg <= {tx_reg[6:0], 1'b0};
                  end
               end
            end
         end else if (ign_reg) begin
            so_oe_n <= 1'b1;
            dq_oe_n <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

//--- tb/frd_decoder_props.sv
`timescale 1ns/1ps
`default_nettype none

module frd_props (
   // clock and reset
   input wire logic       clk,
   input wire logic       resetn,
   // serial pins
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic       si,
   input wire logic       so,
   input wire logic       so_oe_n,
   // octal pins
   input wire logic [7:0] dq_in,
   input wire logic [7:0] dq_out,
   input wire logic       dq_oe_n,
   // device state
   input wire logic       otp_active,
   input wire logic [7:0] spb_bits,
   input wire logic       mem_reset
);
   logic [3:0] cs_hi_cnt;
   logic [3:0] fall_cnt;
   logic       sclk_q;

   // clocks since select went high and since the pin clock fell; saturate in long gaps
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cs_hi_cnt <= 4'h0;
         fall_cnt <= 4'hf;
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk;
         if (!cs_n) cs_hi_cnt <= 4'h0;
         else if (cs_hi_cnt != 4'hf) cs_hi_cnt <= cs_hi_cnt + 4'h1;
         if (sclk_q && !sclk) fall_cnt <= 4'h0;
         else if (fall_cnt != 4'hf) fall_cnt <= fall_cnt + 4'h1;
      end
   end

   // reset values, checked on the edge after any reset cycle
   reset_state_a: assert property (@(posedge clk) !resetn |=> so_oe_n && dq_oe_n
      && !otp_active && spb_bits == 8'h00 && !mem_reset) else $error("reset state wrong");
   released_idle_a: assert property (@(posedge clk) disable iff (!resetn)
      cs_hi_cnt >= 4'h6 |-> so_oe_n && dq_oe_n) else $error("pins driven while idle");
   reset_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
      mem_reset |=> !mem_reset) else $error("memory reset longer than one clock");
   reset_gap_a: assert property (@(posedge clk) disable iff (!resetn)
      mem_reset |-> cs_n && cs_hi_cnt != 4'h0) else $error("memory reset inside frame");
   otp_gap_a: assert property (@(posedge clk) disable iff (!resetn)
      $changed(otp_active) |-> cs_n && cs_hi_cnt != 4'h0) else $error("otp moved in frame");
   spb_gap_a: assert property (@(posedge clk) disable iff (!resetn)
      $changed(spb_bits) |-> cs_n && cs_hi_cnt != 4'h0) else $error("spb moved in frame");
   drive_start_a: assert property (@(posedge clk) disable iff (!resetn)
      $fell(so_oe_n) |-> !cs_n && fall_cnt <= 4'h3) else $error("so enabled off a fall");
   so_fall_a: assert property (@(posedge clk) disable iff (!resetn)
      !so_oe_n && !$past(so_oe_n) && $changed(so) |-> fall_cnt <= 4'h3)
      else $error("so changed off a falling clock");
   one_driver_a: assert property (@(posedge clk) disable iff (!resetn)
      !so_oe_n |-> dq_oe_n) else $error("so and dq driven together");
endmodule

`default_nettype wire

//--- tb/frd_host.sv
`timescale 1ns/1ps
`default_nettype none

module frd_host (
   // clock
   input  wire logic       clk,
   // device outputs
   input  wire logic       so,
   input  wire logic       so_oe_n,
   input  wire logic [7:0] dq_out,
   input  wire logic       dq_oe_n,
   // host pins
   output var  logic       cs_n,
   output var  logic       sclk,
   output var  logic       si,
   output var  logic [7:0] dq_in
);
   logic       octal;
   logic       oe_low;
   logic       last_so;
   logic [7:0] last_dq;

   // deselected, clock parked low between frames
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
      dq_in = 8'h00;
      octal = 1'b0;
      oe_low = 1'b0;
   end

   // one clock period; sample just before the next fall so slow output has settled
   task cyc(input logic [7:0] d);
      begin
         sclk <= 1'b0;
         si <= octal ? ~si : d[0];
         dq_in <= octal ? d : ~dq_in; // unused lines toggle, stale data never looks valid
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         // no pull on these lines: a released pin reads back inverted
         last_so = so_oe_n ? ~so : so;
         last_dq = dq_oe_n ? ~dq_out : dq_out;
         if (so_oe_n === 1'b0 || dq_oe_n === 1'b0) oe_low = 1'b1;
      end
   endtask

   // one byte: eight bits msb first, or one octal beat
   task xfer(input logic [7:0] tx, output logic [7:0] rx);
      integer i;
      begin
         if (octal) begin
            cyc(tx);
            rx = last_dq;
         end else begin
            for (i = 7; i >= 0; i = i - 1) begin
               cyc({7'h00, tx[i]});
               rx = {rx[6:0], last_so};
            end
         end
      end
   endtask

   task frame_begin;
      begin
         @(posedge clk);
         cs_n <= 1'b0;
         oe_low = 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask

   // gap of eight clocks keeps well clear of the minimum deselect time
   task frame_end;
      begin
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         cs_n <= 1'b1;
         si <= ~si;
         repeat (8) @(posedge clk);
      end
   endtask
endmodule

`default_nettype wire

//--- tb/test_frd_decoder.sv
`include "frd_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module test_frd_decoder;
   logic       clk;
   logic       resetn;
   logic       cs_n;
   logic       sclk;
   logic       si;
   logic [7:0] dq_in;
   logic       so;
   logic       so_oe_n;
   logic [7:0] dq_out;
   logic       dq_oe_n;
   logic       otp_active;
   logic [7:0] spb_bits;
   logic       mem_reset;
   int         fails;
   int         n_compared;
   int         n_pulse = 0;
   logic [7:0] rxq[$];
   logic [7:0] sec_val;

   frd_decoder dut (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .si(si),
      .so(so), .so_oe_n(so_oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .otp_active(otp_active), .spb_bits(spb_bits), .mem_reset(mem_reset));
   frd_host host (.clk(clk), .so(so), .so_oe_n(so_oe_n), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .cs_n(cs_n), .sclk(sclk), .si(si), .dq_in(dq_in));

   always #10 clk = ~clk;

   // armed-reset pulses seen so far
   always @(posedge clk) begin
      if (mem_reset === 1'b1) n_pulse <= n_pulse + 1;
   end

   task chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      begin
         n_compared++;
         if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   task chk_bit(input string what, input logic exp, input logic got);
      begin
         chk_byte(what, {7'h00, exp}, {7'h00, got});
      end
   endtask

   task run_frame(input logic [7:0] tx[$], input int ndum, input int nrx);
      logic [7:0] r;
      begin
         rxq = {};
         host.frame_begin();
         foreach (tx[i]) host.xfer(tx[i], r);
         repeat (ndum) host.cyc(8'h00);
         repeat (nrx) begin
            host.xfer(8'h00, r);
            rxq.push_back(r);
         end
         host.frame_end();
      end
   endtask

   task t_reads(input logic [7:0] st, input logic [7:0] cfg, input logic [7:0] cr2);
      begin
         run_frame('{8'h05}, 0, 1);
         chk_byte("status", st, rxq[0]);
         run_frame('{8'h15}, 0, 1);
         chk_byte("config", cfg, rxq[0]);
         run_frame('{8'h2b}, 0, 1);
         chk_byte("security", sec_val, rxq[0]);
         run_frame('{8'h71, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 1);
         chk_byte("cr2", cr2, rxq[0]);
      end
   endtask

   task t_writes;
      begin
         run_frame('{8'h01, 8'h5a}, 0, 0);
         t_reads(8'h5a, `FRD_CONFIG_RST, 8'h00);
         run_frame('{8'h01, 8'ha5, 8'h3c}, 0, 0);
         t_reads(8'ha5, 8'h3c, 8'h00);
         run_frame('{8'h2f}, 0, 1);
         chk_bit("security write quiet", 1'b0, host.oe_low);
         sec_val = 8'h01 << `FRD_SEC_LOCK_BIT;
         t_reads(8'ha5, 8'h3c, 8'h00);
      end
   endtask

   task t_fastboot;
      begin
         run_frame('{8'h17, 8'h11, 8'h22, 8'h33, 8'h44}, 0, 0);
         run_frame('{8'h16}, 0, 5);
         foreach (rxq[i]) chk_byte("fastboot", 8'(8'h11 * (i % 4 + 1)), rxq[i]);
         run_frame('{8'h17, 8'haa, 8'hbb, 8'hcc}, 0, 0);
         run_frame('{8'h16}, 0, 1);
         chk_byte("short fastboot write", 8'h11, rxq[0]);
         run_frame('{8'h18}, 0, 1);
         chk_bit("erase quiet", 1'b0, host.oe_low);
         run_frame('{8'h16}, 0, 4);
         foreach (rxq[i]) chk_byte("fastboot erased", 8'(`FRD_FB_RST >> (8 * i)), rxq[i]);
      end
   endtask

   task t_password;
      begin
         run_frame('{8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
            8'h05, 8'h06, 8'h07, 8'h08}, 0, 0);
         run_frame('{8'h27, 8'h00, 8'h00, 8'h00, 8'h00}, `FRD_PASS_DUMMY_SPI, 8);
         foreach (rxq[i]) chk_byte("password", 8'(i + 1), rxq[i]);
      end
   endtask

   task t_protect;
      begin
         run_frame('{8'hb1}, 0, 0);
         chk_bit("otp entered", 1'b1, otp_active);
         run_frame('{8'hc1}, 0, 0);
         chk_bit("otp left", 1'b0, otp_active);
         run_frame('{8'he3, 8'h00, 8'h05, 8'h00, 8'h00}, 0, 0);
         chk_byte("spb program", 8'h20, spb_bits);
         run_frame('{8'he4}, 0, 0);
         chk_byte("spb erase", 8'h00, spb_bits);
         run_frame('{8'h3a}, 0, 2);
         chk_bit("undefined opcode quiet", 1'b0, host.oe_low);
      end
   endtask

   task t_rst_seq;
      int p;
      begin
         p = n_pulse;
         run_frame('{8'h66}, 0, 0);
         run_frame('{8'h05}, 0, 1);
         run_frame('{8'h99}, 0, 0);
         chk_byte("reset after other", 8'(p), 8'(n_pulse));
         run_frame('{8'h05}, 0, 1);
         chk_byte("status kept", 8'ha5, rxq[0]);
         run_frame('{8'h66}, 0, 0);
         run_frame('{8'h99}, 0, 0);
         chk_byte("armed reset", 8'(p + 1), 8'(n_pulse));
         t_reads(`FRD_STATUS_RST, `FRD_CONFIG_RST, `FRD_CR2_RST);
      end
   endtask

   task t_octal;
      int p;
      begin
         run_frame('{8'h01, 8'h5a}, 0, 0);
         run_frame('{8'h72, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01}, 0, 0);
         host.octal = 1'b1;
         run_frame('{8'h05, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00}, 4, 1);
         chk_bit("bad complement quiet", 1'b0, host.oe_low);
         run_frame('{8'hee, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00}, 20, 1);
         chk_bit("double-rate read in sdr", 1'b0, host.oe_low);
         run_frame('{8'h05, 8'hfa, 8'h00, 8'h00, 8'h00, 8'h00}, `FRD_REG_DUMMY_OCT, 1);
         chk_byte("octal status", 8'h5a, rxq[0]);
         run_frame('{8'hec, 8'h13, 8'h00, 8'h00, 8'h00, 8'h00}, `FRD_ARR_DUMMY_OCT, 1);
         chk_bit("octal read drives", 1'b1, host.oe_low);
         p = n_pulse;
         run_frame('{8'h66, 8'h99}, 0, 0);
         run_frame('{8'h99, 8'h66}, 0, 0);
         chk_byte("octal reset", 8'(p + 1), 8'(n_pulse));
         host.octal = 1'b0;
         t_reads(`FRD_STATUS_RST, `FRD_CONFIG_RST, `FRD_CR2_RST);
      end
   endtask

   task test_done;
      begin
         $display("compared %0d mismatches %0d", n_compared, fails);
         if (fails == 0 && n_compared > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask

   // main sequence
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      fails = 0;
      n_compared = 0;
      sec_val = `FRD_SEC_RST;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_reads(`FRD_STATUS_RST, `FRD_CONFIG_RST, `FRD_CR2_RST);
      t_writes();
      t_fastboot();
      t_password();
      t_protect();
      t_rst_seq();
      t_octal();
      test_done();
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      $display("[ERR] run length expected end seen hang");
      test_done();
   end
endmodule

bind frd_decoder frd_props u_props (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
   .si(si), .so(so), .so_oe_n(so_oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
   .otp_active(otp_active), .spb_bits(spb_bits), .mem_reset(mem_reset));

`default_nettype wire
